// *** rtl/mgs_slave.sv ***
// module: fifo and two-wire slave with control register for the magnetometer
`timescale 1ns/100ps

// ================================================================
// byte fifo
module mgs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ================================================================
// slave top
module mgs_slave
	import mgs_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [1:0]  addr_sel_i,
	input  wire logic        low_voltage_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        measure_complete_i,
	input  wire logic        strap_pulse_complete_i,
	input  wire mgs_result_t result_i,
	input  wire logic        result_valid_i,
	output logic             measure_trigger_o,
	output logic             strap_fwd_o,
	output logic             strap_rev_o,
	output logic             analog_on_o
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ADDR = 5'b00010,
		ST_WR   = 5'b00100,
		ST_RD   = 5'b01000,
		ST_SKIP = 5'b10000
	} mgs_state_t;

	function automatic logic [7:0] next_ptr_f(input logic [7:0] p);
		next_ptr_f = (p >= MGS_REG_YL) ? MGS_REG_CTRL : p + 8'h01;
	endfunction

	// ================================================================
	// input synchronisers and edge detect
	mgs_bus_t   sync1;
	mgs_bus_t   sync2;
	mgs_bus_t   last;
	logic [1:0] strap_meta;
	logic [1:0] strap_sel;
	logic       lv_meta;
	logic       lv_mode;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sync1 <= '{scl: 1'b1, sda: 1'b1};
			sync2 <= '{scl: 1'b1, sda: 1'b1};
			last  <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			sync1 <= '{scl: scl_i, sda: sda_i};
			sync2 <= sync1;
			last  <= sync2;
		end
	end

	// static straps still pass two flops; no reset needed
	always_ff @(posedge clock_i) begin
		strap_meta <= addr_sel_i;
		strap_sel  <= strap_meta;
		lv_meta    <= low_voltage_i;
		lv_mode    <= lv_meta;
	end

	assign scl_rise   = sync2.scl && !last.scl;
	assign scl_fall   = !sync2.scl && last.scl;
	assign start_seen = sync2.scl && last.scl && last.sda && !sync2.sda;
	assign stop_seen  = sync2.scl && last.scl && !last.sda && sync2.sda;

	// ================================================================
	// bit engine
	mgs_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic       ack_phase;
	logic       is_read;
	logic       first_wr_done;
	logic [7:0] ptr;
	logic [7:0] ctrl;
	logic       wr_strobe;
	logic [7:0] wr_byte;
	logic       rd_pop;
	logic       rd_nack;
	logic       own_addr;
	logic [7:0] fifo_data;
	logic       fifo_valid;
	logic       fifo_ready;
	logic [7:0] tx_byte;
	logic [7:0] fill_ptr;
	logic       fill_valid;
	logic [7:0] fill_data;
	logic [15:0] x_word;
	logic [15:0] y_word;

	// fixed bits 0110 and 0 around the strapped pair; direction bit ignored
	assign own_addr = ({shift[7:4], shift[1]} == MGS_ADDR_BASE) && (shift[3:2] == strap_sel);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state     <= ST_IDLE;
			bit_cnt   <= '0;
			shift     <= '0;
			ack_phase <= 1'b0;
			is_read   <= 1'b0;
			wr_strobe <= 1'b0;
			wr_byte   <= '0;
			rd_pop    <= 1'b0;
			rd_nack   <= 1'b0;
		end else begin
			wr_strobe <= 1'b0;
			rd_pop    <= 1'b0;
			if (stop_seen) begin
				state <= ST_IDLE;
			end else if (start_seen) begin
				state     <= ST_ADDR;
				bit_cnt   <= '0;
				ack_phase <= 1'b0;
			end else if (state != ST_IDLE && scl_rise) begin
				if (!ack_phase) begin
					shift   <= {shift[6:0], sync2.sda};
					bit_cnt <= bit_cnt + 4'h1;
				end else if (state == ST_RD) begin
					rd_nack <= sync2.sda; // master nack ends the read
				end
			end else if (state != ST_IDLE && scl_fall) begin
				if (!ack_phase && bit_cnt == MGS_BITS_ACK) begin
					ack_phase <= 1'b1;
					bit_cnt   <= '0;
					case (state)
						ST_ADDR: begin
							if (own_addr) begin
								is_read <= shift[0];
								state   <= shift[0] ? ST_RD : ST_WR;
							end else begin
								state <= ST_SKIP;
							end
						end
						ST_WR: begin
							wr_strobe <= 1'b1;
							wr_byte   <= shift;
						end
						default: begin
						end
					endcase
				end else if (ack_phase) begin
					ack_phase <= 1'b0;
					if (state == ST_RD && is_read) begin
						if (rd_nack) begin
							state <= ST_SKIP;
						end else begin
							rd_pop <= 1'b1;
						end
					end
				end
			end
		end
	end

	// ================================================================
	// pointer and control register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ptr <= MGS_PTR_RESET;
		end else if (wr_strobe && !first_wr_done) begin
			ptr <= wr_byte;
		end else if (rd_pop) begin
			ptr <= next_ptr_f(ptr);
		end
	end

	logic strap_any;
	logic last_fwd;
	logic seen_fwd;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			first_wr_done <= 1'b0;
		end else if (wr_strobe) begin
			first_wr_done <= 1'b1;
		end else if (state != ST_WR) begin
			first_wr_done <= 1'b0;
		end
	end

	// data writes land only at address zero; others ignored
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ctrl     <= MGS_CTRL_RESET;
			seen_fwd <= 1'b0;
		end else begin
			if (measure_complete_i) begin
				ctrl[MGS_BIT_TRIG] <= 1'b0;
			end
			if (strap_pulse_complete_i) begin
				ctrl[MGS_BIT_FWD] <= 1'b0;
				ctrl[MGS_BIT_REV] <= 1'b0;
			end
			if (wr_strobe && first_wr_done && ptr == MGS_REG_CTRL) begin
				if (wr_byte[MGS_BIT_TRIG]) begin
					ctrl[MGS_BIT_TRIG] <= 1'b1;
				end
				if (wr_byte[MGS_BIT_FWD]) begin
					ctrl[MGS_BIT_FWD] <= 1'b1;
					seen_fwd          <= 1'b1;
				end else if (wr_byte[MGS_BIT_REV] && (seen_fwd || !lv_mode)) begin
					ctrl[MGS_BIT_REV] <= 1'b1;
				end
			end
		end
	end

	assign strap_any = ctrl[MGS_BIT_FWD] | ctrl[MGS_BIT_REV];
	assign last_fwd  = ctrl[MGS_BIT_FWD];

	// ================================================================
	// result hold and read fill
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			x_word <= '0;
			y_word <= '0;
		end else if (result_valid_i) begin
			x_word <= {4'h0, result_i.x};
			y_word <= {4'h0, result_i.y};
		end
	end

	always_comb begin
		case (fill_ptr)
			MGS_REG_CTRL: fill_data = ctrl;
			MGS_REG_XH:   fill_data = x_word[15:8];
			MGS_REG_XL:   fill_data = x_word[7:0];
			MGS_REG_YH:   fill_data = y_word[15:8];
			MGS_REG_YL:   fill_data = y_word[7:0];
			default:      fill_data = 8'h00;
		endcase
	end

	// fifo holds one byte ahead; refilled from pointer each read byte
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			fill_ptr   <= MGS_PTR_RESET;
			fill_valid <= 1'b0;
		end else begin
			fill_valid <= 1'b0;
			if (state == ST_ADDR && scl_fall && bit_cnt == MGS_BITS_ACK && shift[0]) begin
				fill_ptr   <= ptr;
				fill_valid <= 1'b1;
			end else if (rd_pop && fifo_ready) begin
				fill_ptr   <= next_ptr_f(ptr);
				fill_valid <= 1'b1;
			end
		end
	end

	mgs_fifo #(
		.WIDTH (MGS_FIFO_WIDTH),
		.DEPTH (MGS_FIFO_DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.rst_i       (rst_i || state == ST_IDLE),
		.in_data_i   (fill_data),
		.in_valid_i  (fill_valid),
		.in_ready_o  (fifo_ready),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (rd_pop)
	);

	// ================================================================
	// data line drive, changed only on falling clock
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tx_byte  <= '0;
			sda_oe_o <= 1'b0;
		end else if (stop_seen || start_seen || state == ST_IDLE || state == ST_SKIP) begin
			sda_oe_o <= 1'b0;
		end else if (scl_fall) begin
			if (!ack_phase && bit_cnt == MGS_BITS_ACK) begin
				sda_oe_o <= (state == ST_ADDR) ? own_addr : (state == ST_WR);
			end else if (state == ST_RD && (ack_phase || (bit_cnt != MGS_BITS_ACK && bit_cnt != '0))) begin
				if (ack_phase) begin
					tx_byte  <= fifo_valid ? fifo_data : 8'h00;
					// after a master nack the line stays free for the stop
					sda_oe_o <= fifo_valid && !rd_nack && !fifo_data[7];
				end else begin
					sda_oe_o <= !tx_byte[3'(MGS_BITS_LAST - bit_cnt)];
				end
			end else begin
				sda_oe_o <= 1'b0;
			end
		end
	end

	assign sda_o = 1'b0;

	// ================================================================
	// analog side requests
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			measure_trigger_o <= 1'b0;
			strap_fwd_o       <= 1'b0;
			strap_rev_o       <= 1'b0;
			analog_on_o       <= 1'b0;
		end else begin
			measure_trigger_o <= ctrl[MGS_BIT_TRIG];
			strap_fwd_o       <= last_fwd;
			strap_rev_o       <= ctrl[MGS_BIT_REV] && !last_fwd;
			analog_on_o       <= ctrl[MGS_BIT_TRIG] || strap_any;
		end
	end
endmodule

// *** rtl/mgs_pkg.sv ***
// package: constants and types for the magnetometer serial slave
package mgs_pkg;
	localparam logic [4:0] MGS_ADDR_BASE    = 5'h0c;
	localparam logic [7:0] MGS_REG_CTRL     = 8'h00;
	localparam logic [7:0] MGS_REG_XH       = 8'h01;
	localparam logic [7:0] MGS_REG_XL       = 8'h02;
	localparam logic [7:0] MGS_REG_YH       = 8'h03;
	localparam logic [7:0] MGS_REG_YL       = 8'h04;
	localparam logic [7:0] MGS_CTRL_RESET   = 8'h00;
	localparam logic [7:0] MGS_PTR_RESET    = 8'h00;
	localparam int         MGS_BIT_TRIG     = 0;
	localparam int         MGS_BIT_FWD      = 1;
	localparam int         MGS_BIT_REV      = 2;
	localparam logic [3:0] MGS_BITS_LAST    = 4'h7;
	localparam logic [3:0] MGS_BITS_ACK     = 4'h8;
	localparam int         MGS_FIFO_WIDTH   = 8;
	localparam int         MGS_FIFO_DEPTH   = 8;

	typedef struct packed {
		logic [11:0] x;
		logic [11:0] y;
	} mgs_result_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} mgs_bus_t;
endpackage

// *** tb/mgs_props.sv ***
// checker: port properties of the magnetometer serial slave
`timescale 1ns/100ps
module mgs_props (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic measure_complete_i,
	input wire logic strap_pulse_complete_i,
	input wire logic measure_trigger_o,
	input wire logic strap_fwd_o,
	input wire logic strap_rev_o,
	input wire logic analog_on_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// ==========
	// properties
	sequence s_rest;
		!measure_trigger_o && !strap_fwd_o && !strap_rev_o;
	endsequence
	sequence s_busy;
		measure_trigger_o || strap_fwd_o || strap_rev_o;
	endsequence
	property p_drain;
		sda_o == 1'b0;
	endproperty
	a_drain: assert property (p_drain) else $error("data pin driven high");
	property p_trig;
		$fell(measure_trigger_o) |-> $past(measure_complete_i) || $past(measure_complete_i, 2);
	endproperty
	a_trig: assert property (p_trig) else $error("trigger cleared without done");
	property p_fwd;
		$fell(strap_fwd_o) |-> $past(strap_pulse_complete_i) || $past(strap_pulse_complete_i, 2);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward cleared without done");
	property p_rev;
		$fell(strap_rev_o) |-> $past(strap_pulse_complete_i) || $past(strap_pulse_complete_i, 2);
	endproperty
	a_rev: assert property (p_rev) else $error("reverse cleared without done");
	property p_excl;
		!(strap_fwd_o && strap_rev_o);
	endproperty
	a_excl: assert property (p_excl) else $error("both strap pulses active");
	// ack and data may only move while the clock pin is low
	property p_oe;
		$changed(sda_oe_o) |-> !scl_i;
	endproperty
	a_oe: assert property (p_oe) else $error("data moved with clock high");
	property p_idle;
		s_rest [*3] |-> !analog_on_o;
	endproperty
	a_idle: assert property (p_idle) else $error("analog left powered");
	property p_busy;
		s_busy ##1 s_busy |-> analog_on_o;
	endproperty
	a_busy: assert property (p_busy) else $error("analog off while busy");
	property p_rst;
		$past(rst_i) |-> !sda_oe_o && !analog_on_o && !measure_trigger_o && !strap_fwd_o;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule

// *** tb/mgs_master.sv ***
// partner: behavioural two-wire bus master
`timescale 1ns/100ps
module mgs_master (
	input  wire logic clock_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// ==========
	// bus phases, slow enough for the two-flop clock pin synchroniser
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic gap();
		repeat (8) @(negedge clock_i);
	endtask
	task automatic put(input logic b, output logic r);
		gap();
		sda_low_o = !b;
		gap();
		scl_o = 1'b1;
		gap();
		r = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic start();
		gap();
		sda_low_o = 1'b0;
		gap();
		scl_o = 1'b1;
		gap();
		sda_low_o = 1'b1;
		gap();
		scl_o = 1'b0;
	endtask
	task automatic stop();
		gap();
		sda_low_o = 1'b1;
		gap();
		scl_o = 1'b1;
		gap();
		sda_low_o = 1'b0;
		gap();
	endtask
	// a = 1 releases the ninth bit, so it is the nack of a read
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) put(d[i], q[i]);
		put(a, k);
	endtask
endmodule

// *** tb/tb_top.sv ***
// testbench: master sequences against the magnetometer serial slave
`timescale 1ns/100ps
module tb_top;
	import mgs_pkg::*;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [1:0]  addr_sel_i = 2'h0;
	logic        low_voltage_i = 1'b0;
	logic        measure_complete_i = 1'b0;
	logic        strap_pulse_complete_i = 1'b0;
	mgs_result_t result_i = '0;
	logic        result_valid_i = 1'b0;
	logic        scl_i, sda_i, sda_o, sda_oe_o, sda_low, k;
	logic        measure_trigger_o, strap_fwd_o, strap_rev_o, analog_on_o;
	logic [7:0]  q;
	int          bad_count = 0;
	int          checked = 0;
	// pull-up, so a released line reads high
	assign sda_i = !(sda_low || sda_oe_o);
	always #10 clock_i = !clock_i;
	mgs_slave i_dut (
		.clock_i                (clock_i),
		.rst_i                  (rst_i),
		.addr_sel_i             (addr_sel_i),
		.low_voltage_i          (low_voltage_i),
		.scl_i                  (scl_i),
		.sda_i                  (sda_i),
		.sda_o                  (sda_o),
		.sda_oe_o               (sda_oe_o),
		.measure_complete_i     (measure_complete_i),
		.strap_pulse_complete_i (strap_pulse_complete_i),
		.result_i               (result_i),
		.result_valid_i         (result_valid_i),
		.measure_trigger_o      (measure_trigger_o),
		.strap_fwd_o            (strap_fwd_o),
		.strap_rev_o            (strap_rev_o),
		.analog_on_o            (analog_on_o)
	);
	mgs_master i_master (.clock_i(clock_i), .sda_i(sda_i), .scl_o(scl_i), .sda_low_o(sda_low));
	// ==========
	// helpers
	function automatic logic [7:0] dev(input logic [1:0] s, input logic r);
		return {4'h6, s, 1'b0, r};
	endfunction
	function automatic logic [7:0] outs();
		return {4'h0, analog_on_o, strap_rev_o, strap_fwd_o, measure_trigger_o};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (bad_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic reset(input logic lv);
		@(negedge clock_i);
		rst_i = 1'b1;
		low_voltage_i = lv;
		repeat (12) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clock_i);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		i_master.start();
		i_master.xfer(dev(addr_sel_i, 1'b0), 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
		i_master.xfer(p, 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
		i_master.xfer(d, 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
		i_master.stop();
		repeat (4) @(negedge clock_i);
	endtask
	task automatic rd(input logic [7:0] p, input int n, input logic [39:0] e);
		wr(p, 8'h00);
		i_master.start();
		i_master.xfer(dev(addr_sel_i, 1'b1), 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
		for (int i = 0; i < n; i++) begin
			i_master.xfer(8'hff, i == n - 1, q, k);
			chk(q, e[39 - 8 * i -: 8]);
		end
		i_master.stop();
	endtask
	task automatic done(input logic m);
		@(negedge clock_i);
		if (m) measure_complete_i = 1'b1;
		else strap_pulse_complete_i = 1'b1;
		@(negedge clock_i);
		measure_complete_i = 1'b0;
		strap_pulse_complete_i = 1'b0;
		repeat (3) @(negedge clock_i);
	endtask
	// ==========
	// tests
	initial begin
		reset(1'b0);
		chk(outs(), 8'h00);
		for (int s = 0; s < 4; s++) begin
			addr_sel_i = 2'(s);
			i_master.start();
			i_master.xfer(dev(2'(s), 1'b0), 1'b1, q, k);
			chk({7'h0, k}, 8'h00);
			i_master.start();
			i_master.xfer(dev(2'(s + 1), 1'b0), 1'b1, q, k);
			chk({7'h0, k}, 8'h01);
			i_master.stop();
		end
		wr(8'h00, 8'h01);
		chk(outs(), 8'h09);
		rd(8'h00, 1, {8'h01, 32'h0});
		result_i = {12'habc, 12'h123};
		@(negedge clock_i);
		result_valid_i = 1'b1;
		@(negedge clock_i);
		result_valid_i = 1'b0;
		done(1'b1);
		chk(outs(), 8'h00);
		rd(8'h00, 5, {8'h00, 8'h0a, 8'hbc, 8'h01, 8'h23});
		rd(8'h03, 2, {8'h01, 8'h23, 24'h0});
		wr(8'h01, 8'h01);
		chk(outs(), 8'h00);
		wr(8'h00, 8'h02);
		chk(outs(), 8'h0a);
		done(1'b0);
		chk(outs(), 8'h00);
		reset(1'b1);
		wr(8'h00, 8'h04);
		chk(outs(), 8'h00);
		wr(8'h00, 8'h06);
		chk(outs(), 8'h0a);
		done(1'b0);
		wr(8'h00, 8'h04);
		chk(outs(), 8'h0c);
		done(1'b0);
		chk(outs(), 8'h00);
		close_out();
	end
	initial begin
		repeat (60000) @(posedge clock_i);
		bad_count++;
		close_out();
	end
endmodule
bind mgs_slave mgs_props i_props (
	.clock_i                (clock_i),
	.rst_i                  (rst_i),
	.scl_i                  (scl_i),
	.sda_o                  (sda_o),
	.sda_oe_o               (sda_oe_o),
	.measure_complete_i     (measure_complete_i),
	.strap_pulse_complete_i (strap_pulse_complete_i),
	.measure_trigger_o      (measure_trigger_o),
	.strap_fwd_o            (strap_fwd_o),
	.strap_rev_o            (strap_rev_o),
	.analog_on_o            (analog_on_o)
);
